/* common/gmr_pkg.sv */
// shared constants for the address-match readback bank
package gmr_pkg;
	localparam int STATION_W = 5;
	localparam int REG_W = 8;
	localparam int OFFSET_W = 5;
	// register offsets in the register set
	localparam logic [4:0] PRIMARY_MATCH_OFFSET = 5'h0C;
	localparam logic [4:0] ALTERNATE_MATCH_OFFSET = 5'h0E;
	// field positions; bits 6:0 shared by both readback registers, top bit used by the alternate only
	localparam int TOP_BIT = 7;
	localparam int TALK_DISABLE_BIT = 6;
	localparam int LISTEN_DISABLE_BIT = 5;
	localparam int STATION_LSB = 0;
	// reset values
	localparam logic [7:0] PRIMARY_MATCH_RESET = 8'h00;
	localparam logic [7:0] ALTERNATE_MATCH_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
	// primary command groups, bits 6:5 of a command byte
	localparam logic [1:0] LISTEN_GROUP = 2'h1;
	localparam logic [1:0] TALK_GROUP = 2'h2;
	// station 31 is the unlisten / untalk code and never addresses anyone
	localparam logic [4:0] UNADDRESS_STATION = 5'h1F;
	localparam int SLOT_FIRST = 0;
	localparam int SLOT_SECOND = 1;
	typedef enum logic [3:0] {
		GMR_MODE_NONE = 4'h0,
		GMR_MODE_NORMAL = 4'h1,
		GMR_MODE_EXTENDED = 4'h2,
		GMR_MODE_NORMAL_DUAL = 4'h3,
		GMR_MODE_EXTENDED_DUAL = 4'h4,
		GMR_MODE_NORMAL_MULTI = 4'h5,
		GMR_MODE_EXTENDED_MULTI = 4'h6,
		GMR_MODE_TALK_ONLY = 4'h7,
		GMR_MODE_LISTEN_ONLY = 4'h8,
		GMR_MODE_TALK_LISTEN = 4'h9
	} gmr_mode_e;
endpackage

/* dv/gmr_bus_partner.sv */
// controller-side model: issues primary commands and data bytes
`timescale 1ns/1ns
`default_nettype none
module gmr_bus_partner (
	input wire logic clk_sys,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	output logic data_accept,
	output logic eoi_line
);
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'hA5;
		data_accept = 1'b0;
		eoi_line = 1'b0;
	end
	// released lines show the inverse so a stale byte cannot match by luck
	task automatic send_cmd(input logic [7:0] b);
		@(posedge clk_sys) #1;
		cmd_valid = 1'b1;
		cmd_byte = b;
		@(posedge clk_sys) #1;
		cmd_valid = 1'b0;
		cmd_byte = ~b;
	endtask
	task automatic send_data(input logic eoi);
		@(posedge clk_sys) #1;
		data_accept = 1'b1;
		eoi_line = eoi;
		@(posedge clk_sys) #1;
		data_accept = 1'b0;
		eoi_line = ~eoi;
	endtask
endmodule // gmr_bus_partner
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the address-match readback bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] mode = 4'h0;
	logic cfg_load = 1'b0, cfg_slot = 1'b0, cfg_t = 1'b0, cfg_l = 1'b0;
	logic [4:0] cfg_st = 5'h00, reg_addr = 5'h00;
	logic reg_rd = 1'b0, reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	wire logic [7:0] rdata, cmd_byte;
	wire logic rvalid, cmd_valid, data_accept, eoi_line;
	wire logic [3:0] hits;
	int fails = 0, checked = 0, cycles = 0;
	always #50 clk_sys = ~clk_sys;
	gmr_bus_partner u_gmr_bus_partner (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .data_accept(data_accept), .eoi_line(eoi_line));
	gmr_match_readback u_gmr_match_readback (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.station_mode_select(mode), .cfg_load(cfg_load), .cfg_slot(cfg_slot),
		.cfg_talk_disable(cfg_t), .cfg_listen_disable(cfg_l), .cfg_station(cfg_st),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .data_accept(data_accept),
		.eoi_line(eoi_line), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
		.first_talk_hit_r(hits[3]), .first_listen_hit_r(hits[2]),
		.second_talk_hit_r(hits[1]), .second_listen_hit_r(hits[0]));
	task automatic give_verdict();
		$display("counts: checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk_sys) #1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk_sys) #1;
		reg_rd = 1'b0;
		cmp({7'h00, rvalid}, 8'h01);
		cmp(rdata, exp);
	endtask
	task automatic cfg(input logic s, input logic t, input logic l, input logic [4:0] st);
		@(posedge clk_sys) #1;
		{cfg_load, cfg_slot, cfg_t, cfg_l, cfg_st} = {1'b1, s, t, l, st};
		@(posedge clk_sys) #1;
		cfg_load = 1'b0;
	endtask
	// hits are registered, so they are due right after the taking edge
	task automatic hit(input logic [7:0] b, input logic [3:0] exp);
		u_gmr_bus_partner.send_cmd(b);
		cmp({4'h0, hits}, {4'h0, exp});
	endtask
	// ceiling well above the roughly 130 cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		rd(5'h0C, 8'h00);
		rd(5'h0E, 8'h00);
		rd(5'h10, 8'h00);
		@(posedge clk_sys) #1;
		{reg_wr, reg_addr, reg_wdata} = {1'b1, 5'h0C, 8'hFF};
		@(posedge clk_sys) #1;
		reg_wr = 1'b0;
		rd(5'h0C, 8'h00);
		$display("test reset and write done");
		cfg(1'b0, 1'b0, 1'b1, 5'h05);
		cfg(1'b1, 1'b1, 1'b0, 5'h09);
		rd(5'h0C, 8'h25);
		rd(5'h0E, 8'h49);
		for (int m = 0; m < 10; m++) begin
			mode = m[3:0];
			hit(8'h45, {m >= 1 && m <= 4, 3'b000});
			hit(8'h25, 4'h0);
			hit(8'h29, {3'b000, m == 3 || m == 4});
			hit(8'h49, 4'h0);
		end
		$display("test mode sweep done");
		mode = 4'h4;
		cfg(1'b0, 1'b1, 1'b0, 5'h05);
		cfg(1'b1, 1'b0, 1'b1, 5'h09);
		hit(8'h25, 4'h4);
		hit(8'h45, 4'h0);
		hit(8'h49, 4'h2);
		hit(8'h29, 4'h0);
		cfg(1'b0, 1'b1, 1'b0, 5'h1F);
		hit(8'h3F, 4'h0);
		$display("test disables done");
		u_gmr_bus_partner.send_data(1'b1);
		rd(5'h0E, 8'hA9);
		u_gmr_bus_partner.send_data(1'b0);
		rd(5'h0E, 8'h29);
		@(posedge clk_sys) #1 sys_rst = 1'b1;
		@(posedge clk_sys) #1 sys_rst = 1'b0;
		rd(5'h0E, 8'h00);
		rd(5'h0C, 8'h00);
		$display("test eoi and reset done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire

/* logic/gmr_match_readback.sv */
// address-match setup readback registers and station compare
`timescale 1ns/1ns
`default_nettype none
// How it works
// RULE_01: first talker disable blocks first talk compare
// RULE_02: first listener disable blocks first listen compare
// RULE_03: first station used only in addressed modes
// RULE_04: dual modes: first station addresses device one
// RULE_05: second talker disable blocks alternate talk compare
// RULE_06: second listener disable blocks alternate listen compare
// RULE_07: alternate station used only in dual modes
// RULE_08: dual modes: alternate station addresses device two
// RULE_09: capture end-or-identify with each accepted byte
// RULE_10: readbacks read-only, zero after reset
module gmr_match_readback #(
	parameter int STATION_W = gmr_pkg::STATION_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] station_mode_select,
	input wire logic cfg_load,
	input wire logic cfg_slot,
	input wire logic cfg_talk_disable,
	input wire logic cfg_listen_disable,
	input wire logic [STATION_W-1:0] cfg_station,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic data_accept,
	input wire logic eoi_line,
	input wire logic [gmr_pkg::OFFSET_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [gmr_pkg::REG_W-1:0] reg_wdata,
	output logic [gmr_pkg::REG_W-1:0] reg_rdata_r,
	output logic reg_rvalid_r,
	output logic first_talk_hit_r,
	output logic first_listen_hit_r,
	output logic second_talk_hit_r,
	output logic second_listen_hit_r
);
	// the readback layout leaves exactly five bits for the station
	if (STATION_W != gmr_pkg::STATION_W) begin : g_bad_station_w
		$error("station number must be five bits wide");
	end

	// configuration held per slot: {talk disable, listen disable, station}
	logic [STATION_W+1:0] first_cfg_r, first_cfg_nxt;
	logic [STATION_W+1:0] second_cfg_r, second_cfg_nxt;
	logic eoi_r, eoi_nxt;
	logic [7:0] rdata_nxt;
	logic rvalid_nxt;
	logic ft_nxt, fl_nxt, st_nxt, sl_nxt;
	logic first_used, second_used;
	logic [7:0] primary_view, alternate_view;
	gmr_pkg::gmr_mode_e mode;

	assign mode = gmr_pkg::gmr_mode_e'(station_mode_select);

	always_comb begin
		// first station is the primary address only in these modes
		first_used = (mode == gmr_pkg::GMR_MODE_NORMAL) //RULE_03
			|| (mode == gmr_pkg::GMR_MODE_EXTENDED)
			|| (mode == gmr_pkg::GMR_MODE_NORMAL_DUAL) //RULE_04
			|| (mode == gmr_pkg::GMR_MODE_EXTENDED_DUAL);
		// the alternate number only matters when a second device exists
		second_used = (mode == gmr_pkg::GMR_MODE_NORMAL_DUAL) //RULE_07
			|| (mode == gmr_pkg::GMR_MODE_EXTENDED_DUAL); //RULE_08
	end

	gmr_station_cmp #(.STATION_W(STATION_W)) u_first_cmp (
		.slot_used(first_used),
		.talk_disable(first_cfg_r[STATION_W+1]), //RULE_01
		.listen_disable(first_cfg_r[STATION_W]), //RULE_02
		.station(first_cfg_r[STATION_W-1:0]),
		.cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte),
		.talk_hit(ft_nxt),
		.listen_hit(fl_nxt)
	);

	gmr_station_cmp #(.STATION_W(STATION_W)) u_second_cmp (
		.slot_used(second_used),
		.talk_disable(second_cfg_r[STATION_W+1]), //RULE_05
		.listen_disable(second_cfg_r[STATION_W]), //RULE_06
		.station(second_cfg_r[STATION_W-1:0]),
		.cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte),
		.talk_hit(st_nxt),
		.listen_hit(sl_nxt)
	);

	always_comb begin
		first_cfg_nxt = first_cfg_r;
		second_cfg_nxt = second_cfg_r;
		if (cfg_load && (cfg_slot == 1'(gmr_pkg::SLOT_FIRST))) begin
			first_cfg_nxt = {cfg_talk_disable, cfg_listen_disable, cfg_station};
		end
		if (cfg_load && (cfg_slot == 1'(gmr_pkg::SLOT_SECOND))) begin
			second_cfg_nxt = {cfg_talk_disable, cfg_listen_disable, cfg_station};
		end
		// line level is sampled only at the moment a byte is taken
		eoi_nxt = data_accept ? eoi_line : eoi_r; //RULE_09
	end

	always_comb begin
		primary_view = gmr_pkg::PRIMARY_MATCH_RESET;
		primary_view[gmr_pkg::TALK_DISABLE_BIT] = first_cfg_r[STATION_W+1];
		primary_view[gmr_pkg::LISTEN_DISABLE_BIT] = first_cfg_r[STATION_W];
		primary_view[gmr_pkg::STATION_LSB +: STATION_W] = first_cfg_r[STATION_W-1:0];
		alternate_view = gmr_pkg::ALTERNATE_MATCH_RESET;
		alternate_view[gmr_pkg::TOP_BIT] = eoi_r; //RULE_09
		alternate_view[gmr_pkg::TALK_DISABLE_BIT] = second_cfg_r[STATION_W+1];
		alternate_view[gmr_pkg::LISTEN_DISABLE_BIT] = second_cfg_r[STATION_W];
		alternate_view[gmr_pkg::STATION_LSB +: STATION_W] = second_cfg_r[STATION_W-1:0];
		rvalid_nxt = reg_rd;
		rdata_nxt = gmr_pkg::UNMAPPED_READ_VALUE;
		// writes are never decoded: the bank has no writable bit
		if (reg_rd) begin //RULE_10
			case (reg_addr)
				gmr_pkg::PRIMARY_MATCH_OFFSET: begin
					rdata_nxt = primary_view;
				end
				gmr_pkg::ALTERNATE_MATCH_OFFSET: begin
					rdata_nxt = alternate_view;
				end
				default: begin
					rdata_nxt = gmr_pkg::UNMAPPED_READ_VALUE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin //RULE_10
			first_cfg_r <= '0;
			second_cfg_r <= '0;
			eoi_r <= 1'b0;
			reg_rdata_r <= gmr_pkg::UNMAPPED_READ_VALUE;
			reg_rvalid_r <= 1'b0;
			first_talk_hit_r <= 1'b0;
			first_listen_hit_r <= 1'b0;
			second_talk_hit_r <= 1'b0;
			second_listen_hit_r <= 1'b0;
		end else begin
			first_cfg_r <= first_cfg_nxt;
			second_cfg_r <= second_cfg_nxt;
			eoi_r <= eoi_nxt;
			reg_rdata_r <= rdata_nxt;
			reg_rvalid_r <= rvalid_nxt;
			first_talk_hit_r <= ft_nxt;
			first_listen_hit_r <= fl_nxt;
			second_talk_hit_r <= st_nxt;
			second_listen_hit_r <= sl_nxt;
		end
	end

	// write data is accepted and dropped
	logic unused_wdata;
	assign unused_wdata = ^reg_wdata;

	// field views used only by the checks below
	logic first_talk_dis, first_listen_dis, second_talk_dis, second_listen_dis;
	logic [STATION_W-1:0] first_station, second_station;
	assign first_talk_dis = first_cfg_r[STATION_W+1];
	assign first_listen_dis = first_cfg_r[STATION_W];
	assign first_station = first_cfg_r[STATION_W-1:0];
	assign second_talk_dis = second_cfg_r[STATION_W+1];
	assign second_listen_dis = second_cfg_r[STATION_W];
	assign second_station = second_cfg_r[STATION_W-1:0];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_first_talk_off: assert property ( //RULE_01
		cmd_valid && first_talk_dis |=> !first_talk_hit_r)
		else $error("first talker hit while disabled");
	chk_first_listen_off: assert property ( //RULE_02
		cmd_valid && first_listen_dis |=> !first_listen_hit_r)
		else $error("first listener hit while disabled");
	chk_first_mode_gate: assert property ( //RULE_03
		(first_talk_hit_r || first_listen_hit_r)
		|-> ($past(station_mode_select) inside {4'h1, 4'h2, 4'h3, 4'h4}))
		else $error("first station matched in a mode that does not use it");
	chk_dual_first_talk: assert property ( //RULE_04
		cmd_valid && mode == gmr_pkg::GMR_MODE_NORMAL_DUAL && !first_talk_dis
		&& cmd_byte == {1'b0, gmr_pkg::TALK_GROUP, first_station}
		&& first_station != gmr_pkg::UNADDRESS_STATION |=> first_talk_hit_r)
		else $error("dual mode talk to device one missed");
	chk_second_talk_off: assert property ( //RULE_05
		cmd_valid && second_talk_dis |=> !second_talk_hit_r)
		else $error("second talker hit while disabled");
	chk_second_listen_off: assert property ( //RULE_06
		cmd_valid && second_listen_dis |=> !second_listen_hit_r)
		else $error("second listener hit while disabled");
	chk_second_mode_gate: assert property ( //RULE_07
		(second_talk_hit_r || second_listen_hit_r)
		|-> ($past(station_mode_select) inside {4'h3, 4'h4}))
		else $error("alternate station matched outside dual modes");
	chk_dual_second_listen: assert property ( //RULE_08
		cmd_valid && mode == gmr_pkg::GMR_MODE_EXTENDED_DUAL && !second_listen_dis
		&& cmd_byte == {1'b0, gmr_pkg::LISTEN_GROUP, second_station}
		&& second_station != gmr_pkg::UNADDRESS_STATION |=> second_listen_hit_r)
		else $error("dual mode listen to device two missed");
	chk_eoi_capture: assert property ( //RULE_09
		data_accept |=> eoi_r == $past(eoi_line))
		else $error("captured end-or-identify level wrong");
	chk_eoi_hold: assert property ( //RULE_09
		!data_accept |=> $stable(eoi_r))
		else $error("end-or-identify capture moved without a data byte");
	chk_eoi_read: assert property ( //RULE_09
		reg_rd && reg_addr == gmr_pkg::ALTERNATE_MATCH_OFFSET
		|=> reg_rdata_r[gmr_pkg::TOP_BIT] == $past(eoi_r))
		else $error("alternate read lost the captured end-or-identify");
	chk_write_no_effect: assert property ( //RULE_10
		reg_wr && !cfg_load && !data_accept
		|=> $stable(first_cfg_r) && $stable(second_cfg_r) && $stable(eoi_r))
		else $error("register write changed readback state");
	chk_unmapped_zero: assert property ( //RULE_10
		reg_rd && reg_addr != gmr_pkg::PRIMARY_MATCH_OFFSET
		&& reg_addr != gmr_pkg::ALTERNATE_MATCH_OFFSET
		|=> reg_rvalid_r && reg_rdata_r == 8'h00)
		else $error("unmapped read returned nonzero");
	chk_primary_layout: assert property ( //RULE_03
		reg_rd && reg_addr == gmr_pkg::PRIMARY_MATCH_OFFSET
		|=> reg_rdata_r == {1'b0, $past(first_cfg_r)})
		else $error("primary readback layout wrong");
	chk_read_answer: assert property ( //RULE_10
		reg_rd |=> reg_rvalid_r)
		else $error("read strobe got no answer");
	chk_idle_quiet: assert property ( //RULE_10
		!reg_rd |=> !reg_rvalid_r && reg_rdata_r == 8'h00)
		else $error("read data shown without a read");

	cov_first_talk: cover property (first_talk_hit_r);
	cov_first_listen: cover property (first_listen_hit_r);
	cov_second_talk: cover property (second_talk_hit_r);
	cov_second_listen: cover property (second_listen_hit_r);
	cov_eoi_read: cover property (reg_rvalid_r && reg_rdata_r[7]);
endmodule // gmr_match_readback
`default_nettype wire

/* logic/gmr_station_cmp.sv */
// compares one station number against a primary talk or listen command
`timescale 1ns/1ns
`default_nettype none
module gmr_station_cmp #(
	parameter int STATION_W = gmr_pkg::STATION_W
) (
	input wire logic slot_used,
	input wire logic talk_disable,
	input wire logic listen_disable,
	input wire logic [STATION_W-1:0] station,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	output logic talk_hit,
	output logic listen_hit
);
	// the compare slices a five-bit station out of the command byte
	if (STATION_W != gmr_pkg::STATION_W) begin : g_bad_station_w
		$error("station number must be five bits wide");
	end
	logic station_eq;
	always_comb begin
		station_eq = slot_used && cmd_valid && (cmd_byte[4:0] == station)
			&& (cmd_byte[4:0] != gmr_pkg::UNADDRESS_STATION);
		// a disabled talker or listener is masked after the compare, so it can never be addressed
		talk_hit = station_eq && !talk_disable && (cmd_byte[6:5] == gmr_pkg::TALK_GROUP);
		listen_hit = station_eq && !listen_disable
			&& (cmd_byte[6:5] == gmr_pkg::LISTEN_GROUP);
	end
endmodule // gmr_station_cmp
`default_nettype wire
